// >>> hdl/startup_mode_pkg.sv
// Constants for the start-up mode selection and logic pin routing block
package startup_mode_pkg;
	// Three-level mode pin as resolved by the pad comparators
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_FLOAT = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	// Register initialization source
	localparam logic SRC_EEPROM = 1'h0;
	localparam logic SRC_ROM = 1'h1;
	// Logic pin positions
	localparam int PIN_SYNC = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDO = 2;
	localparam int PIN_DEC1 = 4;
	localparam int PIN_INC1 = 3;
	localparam int PIN_DEC2 = 6;
	localparam int PIN_INC2 = 5;
	localparam int NUM_PINS = 7;
	// Reference qualification thresholds in ppm
	localparam int VALID_PPM = 55;
	localparam int INVALID_PPM = 60;
	localparam int PPM_W = 16;
	// Reset values
	localparam logic [3:0] PAGE_RST = 4'h0;
	localparam logic [1:0] ADDR_LSB_RST = 2'h0;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [3:0] VALID_RST = 4'h0;
	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_LOAD = 3'h2,
		ST_RUN = 3'h4
	} phase_t;
endpackage

// >>> hdl/startup_mode_config_select.sv
// Start-up mode latch, logic pin routing, reference qualification and selection
`timescale 1ns/1ps
// Contract
// - At reset the three-level mode pin is sampled and picks init source, serial port and pin roles.
// - Low selects EEPROM initialization with the I2C port.
// - Floating selects EEPROM initialization with the SPI port.
// - High selects ROM initialization from a pin-chosen page with the I2C port.
// - In ROM mode logic pins 3 to 0 form the binary page number of sixteen pages.
// - In EEPROM plus I2C mode logic pins 2 and 1 give the two low I2C address bits.
// - In EEPROM modes logic pin 0 is an active-low output sync input.
// - In EEPROM modes logic pins 4 and 3 are active-high step down and up for loop one.
// - In EEPROM modes logic pins 6 and 5 are loop two step requests or status outputs.
// - In SPI mode the I2C pins carry data in and clock, pin 1 is select and pin 2 data out.
// - Both serial ports reach one identical register map.
// - A reference is valid below 55 ppm offset, invalid above 60 ppm, hysteresis between.
// - Status pin zero shows loss of lock of loop one and status pin one of loop two.
// - Each loop picks its reference automatically, non-revertive, input 0 first.
// - A power-down reset pulse reloads the registers from EEPROM or ROM, per the resampled mode, as at power-up.
module startup_mode_config_select (
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_down_reset_pin,
	input wire logic [1:0] startup_mode_select_pin,
	input wire logic [6:0] logic_pin_in,
	output logic [6:0] logic_pin_out,
	output logic [6:0] logic_pin_oe,
	input wire logic sda_in,
	input wire logic scl_in,
	input wire logic spi_sdo_data,
	input wire logic status_on_pins,
	input wire logic [3:0] holdover_active,
	input wire logic loop_one_locked,
	input wire logic loop_two_locked,
	input wire logic [4*startup_mode_pkg::PPM_W-1:0] ref_offset_ppm,
	output logic load_start,
	output logic init_source,
	output logic spi_enable,
	output logic i2c_enable,
	output logic [3:0] rom_page,
	output logic [1:0] i2c_addr_lsb,
	output logic output_sync,
	output logic freq_step_down_request_one,
	output logic freq_step_up_request_one,
	output logic freq_step_down_request_two,
	output logic freq_step_up_request_two,
	output logic serial_chip_select,
	output logic serial_clock,
	output logic serial_data_in,
	output logic status_pin_zero,
	output logic status_pin_one,
	output logic [3:0] ref_valid,
	output logic [1:0] loop_one_sel,
	output logic [1:0] loop_two_sel,
	output logic loop_one_has_ref,
	output logic loop_two_has_ref
);
	startup_mode_pkg::phase_t phase_ff;
	logic pdn_ff;
	logic [1:0] mode_ff;
	logic eeprom_mode;
	logic spi_mode;
	logic [3:0] ref_valid_ff;
	logic [1:0] sel_one_ff;
	logic [1:0] sel_two_ff;
	logic have_one_ff;
	logic have_two_ff;
	logic [3:0] nxt_valid;

	// Highest-priority valid input, 0 first
	function automatic logic [1:0] first_valid(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h3;
		if (v[2]) r = 2'h2;
		if (v[1]) r = 2'h1;
		if (v[0]) r = 2'h0;
		return r;
	endfunction

	// Power-down acts as a second reset: mode is resampled and a reload follows
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pdn_ff <= 1'b1;
		end else begin
			pdn_ff <= power_down_reset_pin;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_ff <= startup_mode_pkg::ST_RESET;
		end else if (pdn_ff) begin
			phase_ff <= startup_mode_pkg::ST_RESET;
		end else begin
			case (phase_ff)
				startup_mode_pkg::ST_RESET: phase_ff <= startup_mode_pkg::ST_LOAD;
				startup_mode_pkg::ST_LOAD: phase_ff <= startup_mode_pkg::ST_RUN;
				startup_mode_pkg::ST_RUN: phase_ff <= startup_mode_pkg::ST_RUN;
				default: phase_ff <= startup_mode_pkg::ST_RESET;
			endcase
		end
	end

	// Mode pin tracked only while held in reset; frozen once running
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_ff <= startup_mode_pkg::LVL_LOW;
		end else if (phase_ff == startup_mode_pkg::ST_RESET) begin
			mode_ff <= startup_mode_select_pin;
		end
	end

	// Strapped inputs caught together with the mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rom_page <= startup_mode_pkg::PAGE_RST;
			i2c_addr_lsb <= startup_mode_pkg::ADDR_LSB_RST;
		end else if (phase_ff == startup_mode_pkg::ST_RESET) begin
			rom_page <= logic_pin_in[3:0];
			i2c_addr_lsb <= logic_pin_in[2:1];
		end
	end

	// Unknown pin code falls back to the default EEPROM plus I2C mode
	assign spi_mode = (mode_ff == startup_mode_pkg::LVL_FLOAT);
	assign eeprom_mode = (mode_ff != startup_mode_pkg::LVL_HIGH);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			load_start <= 1'b0;
			init_source <= startup_mode_pkg::SRC_EEPROM;
			spi_enable <= 1'b0;
			i2c_enable <= 1'b0;
		end else begin
			load_start <= (phase_ff == startup_mode_pkg::ST_LOAD);
			init_source <= eeprom_mode ? startup_mode_pkg::SRC_EEPROM
				: startup_mode_pkg::SRC_ROM;
			// One register map sits behind whichever port is enabled
			spi_enable <= (phase_ff == startup_mode_pkg::ST_RUN) && spi_mode;
			i2c_enable <= (phase_ff == startup_mode_pkg::ST_RUN) && !spi_mode;
		end
	end

	// Pin roles in the running phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_sync <= 1'b0;
			freq_step_down_request_one <= 1'b0;
			freq_step_up_request_one <= 1'b0;
			freq_step_down_request_two <= 1'b0;
			freq_step_up_request_two <= 1'b0;
			serial_chip_select <= 1'b0;
			serial_clock <= 1'b0;
			serial_data_in <= 1'b0;
		end else begin
			output_sync <= eeprom_mode && !logic_pin_in[startup_mode_pkg::PIN_SYNC];
			freq_step_down_request_one <= eeprom_mode
				&& logic_pin_in[startup_mode_pkg::PIN_DEC1];
			freq_step_up_request_one <= eeprom_mode && logic_pin_in[startup_mode_pkg::PIN_INC1];
			freq_step_down_request_two <= eeprom_mode && !status_on_pins
				&& logic_pin_in[startup_mode_pkg::PIN_DEC2];
			freq_step_up_request_two <= eeprom_mode && !status_on_pins
				&& logic_pin_in[startup_mode_pkg::PIN_INC2];
			// Chip select is active low on the pin
			serial_chip_select <= spi_mode && !logic_pin_in[startup_mode_pkg::PIN_CS];
			serial_clock <= spi_mode && scl_in;
			serial_data_in <= spi_mode && sda_in;
		end
	end

	// Pin drivers; outputs stay released while in reset so straps read cleanly
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			logic_pin_out <= 7'h00;
			logic_pin_oe <= 7'h00;
		end else begin
			logic_pin_out <= 7'h00;
			logic_pin_oe <= 7'h00;
			if (phase_ff == startup_mode_pkg::ST_RUN) begin
				if (spi_mode) begin
					logic_pin_out[startup_mode_pkg::PIN_SDO] <= spi_sdo_data;
					logic_pin_oe[startup_mode_pkg::PIN_SDO] <= !logic_pin_in[startup_mode_pkg::PIN_CS];
				end
				// ROM mode always shows status; EEPROM modes only when configured
				if (!eeprom_mode || status_on_pins) begin
					// Pin 5 shows loop one holdover, pin 6 loop two
					logic_pin_out[startup_mode_pkg::PIN_INC2] <= holdover_active[0];
					logic_pin_out[startup_mode_pkg::PIN_DEC2] <= holdover_active[1];
					logic_pin_oe[startup_mode_pkg::PIN_DEC2] <= 1'b1;
					logic_pin_oe[startup_mode_pkg::PIN_INC2] <= 1'b1;
				end
			end
		end
	end

	// Status pins are left released during reset so a floating strap is not disturbed
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_pin_zero <= 1'b0;
			status_pin_one <= 1'b0;
		end else begin
			status_pin_zero <= (phase_ff == startup_mode_pkg::ST_RUN) && !loop_one_locked;
			status_pin_one <= (phase_ff == startup_mode_pkg::ST_RUN) && !loop_two_locked;
		end
	end

	// Hysteresis: between thresholds the previous verdict holds
	always_comb begin
		logic [startup_mode_pkg::PPM_W-1:0] off;
		off = '0;
		nxt_valid = ref_valid_ff;
		for (int i = 0; i < 4; i++) begin
			off = ref_offset_ppm[i*startup_mode_pkg::PPM_W +: startup_mode_pkg::PPM_W];
			if (off < startup_mode_pkg::PPM_W'(startup_mode_pkg::VALID_PPM)) begin
				nxt_valid[i] = 1'b1;
			end else if (off > startup_mode_pkg::PPM_W'(startup_mode_pkg::INVALID_PPM)) begin
				nxt_valid[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_valid_ff <= startup_mode_pkg::VALID_RST;
		end else begin
			ref_valid_ff <= nxt_valid;
		end
	end

	// Non-revertive: keep the current input while it stays valid
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_one_ff <= startup_mode_pkg::SEL_RST;
			sel_two_ff <= startup_mode_pkg::SEL_RST;
			have_one_ff <= 1'b0;
			have_two_ff <= 1'b0;
		end else begin
			if (!(have_one_ff && ref_valid_ff[sel_one_ff])) begin
				sel_one_ff <= first_valid(ref_valid_ff);
				have_one_ff <= |ref_valid_ff;
			end
			if (!(have_two_ff && ref_valid_ff[sel_two_ff])) begin
				sel_two_ff <= first_valid(ref_valid_ff);
				have_two_ff <= |ref_valid_ff;
			end
		end
	end

	assign ref_valid = ref_valid_ff;
	assign loop_one_sel = sel_one_ff;
	assign loop_two_sel = sel_two_ff;
	assign loop_one_has_ref = have_one_ff;
	assign loop_two_has_ref = have_two_ff;
endmodule

// >>> verif/startup_mode_asserts.sv
// Checker for the start-up mode latch and logic pin routing
`timescale 1ns/1ps
module startup_mode_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_down_reset_pin,
	input wire logic [6:0] logic_pin_in,
	input wire logic loop_one_locked,
	input wire logic load_start,
	input wire logic init_source,
	input wire logic spi_enable,
	input wire logic i2c_enable,
	input wire logic output_sync,
	input wire logic freq_step_up_request_one,
	input wire logic serial_chip_select,
	input wire logic status_pin_zero
);
	logic run;
	assign run = spi_enable | i2c_enable;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	load_pulse_a: assert property (load_start |=> !load_start && run)
		else $error("load pulse wrong");
	port_excl_a: assert property (!(spi_enable && i2c_enable))
		else $error("both ports on");
	rom_port_a: assert property (run && init_source |-> i2c_enable)
		else $error("rom without i2c");
	spi_source_a: assert property ($rose(spi_enable) |-> !init_source)
		else $error("spi without eeprom");
	mode_hold_a: assert property (run && !power_down_reset_pin && !$past(power_down_reset_pin)
		|=> $stable(init_source) && $stable(spi_enable))
		else $error("mode changed");
	sync_route_a: assert property (run && $past(run) && !init_source
		|-> output_sync == !$past(logic_pin_in[0]))
		else $error("sync routing");
	step_route_a: assert property (run && $past(run) && !init_source
		|-> freq_step_up_request_one == $past(logic_pin_in[3]))
		else $error("step routing");
	chip_select_a: assert property (spi_enable && $past(spi_enable)
		|-> serial_chip_select == !$past(logic_pin_in[1]))
		else $error("chip select");
	lock_status_a: assert property (run && $past(run)
		|-> status_pin_zero == !$past(loop_one_locked))
		else $error("lock status");
	cover property (load_start && init_source);
	cover property ($rose(spi_enable));
	cover property (power_down_reset_pin ##1 !power_down_reset_pin);
endmodule
bind startup_mode_config_select startup_mode_asserts i_chk (.mclk, .rst,
	.power_down_reset_pin, .logic_pin_in, .loop_one_locked, .load_start, .init_source,
	.spi_enable, .i2c_enable, .output_sync, .freq_step_up_request_one, .serial_chip_select,
	.status_pin_zero);

// >>> verif/host_model.sv
// Host stand-in that sends one SPI frame; it never touches the status pins
`timescale 1ns/1ps
module host_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [7:0] tx,
	output logic sclk,
	output logic sdi,
	output logic cs_n
);
	int n = 0;
	initial begin
		sclk = 1'h0;
		sdi = 1'h0;
		cs_n = 1'h1;
	end
	// Clock parks low between frames; released data flips so stale bits never look valid
	always @(negedge mclk) begin
		if (n != 0) begin
			n <= n - 1;
			sclk <= n[0];
			if (!n[0]) sdi <= tx[(n-1)/2];
		end else if (go && cs_n) begin
			cs_n <= 1'h0;
			n <= 16;
		end else begin
			cs_n <= 1'h1;
			sclk <= 1'h0;
			if (!cs_n) sdi <= ~sdi;
		end
	end
endmodule

// >>> verif/startup_mode_config_select_tb_top.sv
// Self-checking bench for the start-up mode block
`timescale 1ns/1ps
module startup_mode_config_select_tb_top;
	logic mclk = 1'h0, rst = 1'h1, power_down_reset_pin = 1'h0, status_on_pins = 1'h0;
	logic loop_one_locked = 1'h0, loop_two_locked = 1'h0, go = 1'h0, spi = 1'h0, src;
	logic [1:0] startup_mode_select_pin = 2'h0;
	logic [6:0] pins = 7'h0;
	logic [3:0] holdover_active = 4'h0, ev = 4'hF;
	logic [63:0] ref_offset_ppm = 64'h0;
	logic [7:0] tx = 8'hA5;
	logic sclk, sdi, cs_n, load_start, init_source, spi_enable, i2c_enable, output_sync;
	logic freq_step_down_request_one, freq_step_up_request_one, freq_step_down_request_two;
	logic freq_step_up_request_two, serial_chip_select, status_pin_zero, status_pin_one;
	logic loop_one_has_ref, loop_two_has_ref, serial_clock, serial_data_in, stat;
	logic sdo = 1'h0, sclk_q = 1'h0;
	logic [7:0] rx = 8'h0;
	logic [3:0] rom_page, ref_valid;
	logic [1:0] i2c_addr_lsb, loop_one_sel, loop_two_sel;
	logic [6:0] logic_pin_in, logic_pin_out, logic_pin_oe;
	// Code 3 is not a documented level; it must fall back to EEPROM plus I2C
	logic [1:0] mtab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	int err_total = 0, tests_run = 0, seed = 625, v, msel, nbits = 0;
	assign logic_pin_in = {pins[6:2], spi ? cs_n : pins[1], pins[0]};
	startup_mode_config_select i_dut (.mclk, .rst, .power_down_reset_pin,
		.startup_mode_select_pin, .logic_pin_in, .logic_pin_out, .logic_pin_oe,
		.sda_in(sdi), .scl_in(sclk), .spi_sdo_data(sdo), .status_on_pins, .holdover_active,
		.loop_one_locked, .loop_two_locked, .ref_offset_ppm, .load_start, .init_source,
		.spi_enable, .i2c_enable, .rom_page, .i2c_addr_lsb, .output_sync,
		.freq_step_down_request_one, .freq_step_up_request_one, .freq_step_down_request_two,
		.freq_step_up_request_two, .serial_chip_select, .serial_clock, .serial_data_in,
		.status_pin_zero, .status_pin_one, .ref_valid, .loop_one_sel, .loop_two_sel,
		.loop_one_has_ref, .loop_two_has_ref);
	host_model i_host (.mclk, .go, .tx, .sclk, .sdi, .cs_n);
	initial forever #5 mclk = ~mclk;
	// Reference model of non-revertive selection: keep a valid input, else lowest valid
	function automatic int pick(input int cur, input logic [3:0] e);
		if (cur >= 0 && e[cur]) return cur;
		for (int j = 0; j < 4; j++) begin
			if (e[j]) return j;
		end
		return -1;
	endfunction
	// Routed SPI bits taken on the falling edge, where the registered copies are settled
	always @(negedge mclk) begin
		sclk_q <= serial_clock;
		if (serial_clock && !sclk_q) begin
			rx <= {rx[6:0], serial_data_in};
			nbits <= nbits + 1;
		end
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("Checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task wait_load;
		for (int i = 0; i < 20 && load_start !== 1'h1; i++) @(negedge mclk);
		if (load_start !== 1'h1) begin
			err_total++;
			stop_test;
		end
	endtask
	initial begin
		foreach (mtab[k]) begin
			startup_mode_select_pin = mtab[k];
			src = mtab[k] == startup_mode_pkg::LVL_HIGH;
			spi = mtab[k] == startup_mode_pkg::LVL_FLOAT;
			pins = 7'($random(seed));
			rst = 1'h1;
			repeat (16) @(negedge mclk);
			rst = 1'h0;
			msel = pick(-1, ev);
			wait_load;
			chk(init_source, src);
			@(negedge mclk);
			chk(spi_enable, spi);
			chk(i2c_enable, !spi);
			if (src) chk(rom_page, pins[3:0]);
			if (!src && !spi) chk(i2c_addr_lsb, pins[2:1]);
			// Late mode and strap changes must not leak into the latched mode
			startup_mode_select_pin = mtab[k] ^ 2'h3;
			{pins, status_on_pins, loop_one_locked, loop_two_locked, holdover_active, sdo} =
				15'($random(seed));
			stat = src || status_on_pins;
			for (int j = 0; j < 4; j++) begin
				v = {$random(seed)} % 100;
				if (v >= startup_mode_pkg::VALID_PPM && v <= startup_mode_pkg::INVALID_PPM) v = 70;
				ref_offset_ppm[16*j +: 16] = v[15:0];
				ev[j] = v < startup_mode_pkg::VALID_PPM;
			end
			msel = pick(msel, ev);
			repeat (3) @(negedge mclk);
			chk(init_source, src);
			chk(spi_enable, spi);
			chk(ref_valid, ev);
			chk(loop_one_has_ref, |ev);
			if (|ev) chk(ev[loop_one_sel], 1'h1);
			chk({loop_one_has_ref, loop_two_has_ref}, {2{msel >= 0}});
			if (msel >= 0) chk({loop_one_sel, loop_two_sel}, {2{msel[1:0]}});
			chk(logic_pin_oe, {stat, stat, 5'h0});
			chk(logic_pin_out & logic_pin_oe, {{2{stat}} & holdover_active[1:0], 5'h0});
			chk({status_pin_zero, status_pin_one}, {!loop_one_locked, !loop_two_locked});
			chk(output_sync, !src && !pins[0]);
			chk(freq_step_down_request_one, !src && pins[4]);
			chk(freq_step_up_request_one, !src && pins[3]);
			chk(freq_step_down_request_two, !stat && pins[6]);
			chk(freq_step_up_request_two, !stat && pins[5]);
			if (spi) begin
				tx = 8'($random(seed));
				go <= 1'h1;
				@(negedge mclk);
				go <= 1'h0;
				repeat (2) @(negedge mclk);
				chk(serial_chip_select, 1'h1);
				chk({logic_pin_oe[2], logic_pin_out[2]}, {1'h1, sdo});
				repeat (20) @(negedge mclk);
				chk(rx, tx);
				chk(8'(nbits), 8'h8);
			end
			startup_mode_select_pin = mtab[k];
			power_down_reset_pin = 1'h1;
			repeat (2) @(negedge mclk);
			power_down_reset_pin = 1'h0;
			wait_load;
			chk(init_source, src);
		end
		stop_test;
	end
endmodule
